// ### mmd_regs.vh
`ifndef MMD_REGS_VH
`define MMD_REGS_VH

// Address width of the 2K space
`define MMD_AW 11

// Register offsets in the I/O window
`define MMD_PORT_A_OUTPUT_LATCH 11'h000
`define MMD_PORT_B_OUTPUT_LATCH 11'h001
`define MMD_PORT_A_DIRECTION 11'h004
`define MMD_PORT_B_DIRECTION 11'h005
`define MMD_TIMER_CTRL_STATUS 11'h008
`define MMD_TIMER_COUNT_VALUE 11'h009
`define MMD_EXT_IRQ_CTRL_STATUS 11'h00a
`define MMD_PORT_A_PULL_ENABLE 11'h010
`define MMD_PORT_B_PULL_ENABLE 11'h011
`define MMD_FACTORY_TEST_REG 11'h01f

// Region bounds, inclusive
`define MMD_IO_LO 11'h000
`define MMD_IO_HI 11'h01f
`define MMD_RAM_LO 11'h0c0
`define MMD_RAM_HI 11'h0ff
`define MMD_UROM_LO 11'h300
`define MMD_UROM_HI 11'h7cf
`define MMD_TROM_LO 11'h7d0
`define MMD_TROM_HI 11'h7f7
`define MMD_VROM_LO 11'h7f8
`define MMD_VROM_HI 11'h7ff

// Region codes from the decoder
`define MMD_RG_NONE 3'h0
`define MMD_RG_IO 3'h1
`define MMD_RG_RAM 3'h2
`define MMD_RG_UROM 3'h3
`define MMD_RG_TROM 3'h4
`define MMD_RG_VROM 3'h5

// RAM depth and index width
`define MMD_RAM_DEPTH 64
`define MMD_RAM_AW 6

// Port B direction byte fields
`define MMD_DIRB_SLOW_BIT 7
// Timer control and status fields
`define MMD_TC_TOF_BIT 7
`define MMD_TC_RTIF_BIT 6
`define MMD_TC_TOFE_BIT 5
`define MMD_TC_RTIE_BIT 4
`define MMD_TC_TOFR_BIT 3
`define MMD_TC_RTIFR_BIT 2
// External interrupt control and status fields
`define MMD_IC_IRQE_BIT 7
`define MMD_IC_IRQE1_BIT 6
`define MMD_IC_IRQF_BIT 3
`define MMD_IC_IRQF1_BIT 2
`define MMD_IC_IRQR_BIT 1
`define MMD_IC_IRQR1_BIT 0

// Reset values
`define MMD_RST_BYTE 8'h00
`define MMD_RST_SIX 6'h00
`define MMD_RST_TWO 2'h0
// Value read back where nothing drives data
`define MMD_RD_FILL 8'h00

`endif

// ### mmd_ram.v
`timescale 1ns/1ps
`default_nettype none
`include "mmd_regs.vh"

module mmd_ram #(
	parameter DEPTH = `MMD_RAM_DEPTH,
	parameter AW = `MMD_RAM_AW
) (
	// Clock
	input wire clk_i,
	input wire reset_i,
	// Write port
	input wire wr_i,
	input wire [AW-1:0] waddr_i,
	input wire [7:0] wdata_i,
	// Read port
	input wire rd_i,
	input wire [AW-1:0] raddr_i,
	input wire alt_sel_i,
	input wire [7:0] alt_data_i,
	// Registered read data
	output reg [7:0] rdata_o
);

	// Storage array, no reset
	reg [7:0] mem_q [0:DEPTH-1];

	// Write into the array
	always @(posedge clk_i) begin
		if (wr_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
	end

	// Read register, also carries non-RAM read data
	always @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= `MMD_RST_BYTE;
		end else if (rd_i) begin
			if (alt_sel_i) begin
				rdata_o <= alt_data_i;
			end else begin
				rdata_o <= mem_q[raddr_i];
			end
		end
	end

endmodule
`default_nettype wire

// ### mmd_memory_map_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "mmd_regs.vh"

// Contract
// - Decode 2K space: I/O, RAM, ROM
// - I/O registers at 0x000 to 0x01F
// - Unimplemented bits: read undefined, write ignored
// - 64 bytes RAM at 0x0C0 to 0x0FF
// - Stack shares RAM, grows down from 0x0FF
// - User ROM at 0x300 to 0x7CF
// - Vector ROM at 0x7F8 to 0x7FF
// - Test ROM at 0x7D0 to 0x7F7
// - Port data 0/1, direction 4/5
// - Timer control 0x008, counter 0x009
// - Interrupt control 0x00A, rest unimplemented
// - Pull enables at 0x010 and 0x011
// - 0x01F factory test, no user effect
module mmd_memory_map_decode #(
	parameter AW = `MMD_AW,
	parameter PA_W = 8,
	parameter PB_W = 6
) (
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Register bus from the CPU
	input wire [AW-1:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output wire [7:0] rdata_o,
	// ROM data for the presented address
	input wire [7:0] urom_data_i,
	input wire [7:0] trom_data_i,
	// Port pins, asynchronous
	input wire [PA_W-1:0] pa_pin_i,
	input wire [PB_W-1:0] pb_pin_i,
	// Timer state from the timer logic
	input wire tof_i,
	input wire rtif_i,
	input wire [7:0] tmr_count_i,
	// Interrupt flags from the interrupt logic
	input wire irqf_i,
	input wire irqf1_i,
	// Port controls
	output reg [PA_W-1:0] port_a_output_latch_o,
	output reg [PB_W-1:0] port_b_output_latch_o,
	output reg [PA_W-1:0] port_a_direction_o,
	output reg [PB_W-1:0] port_b_direction_o,
	output reg slow_edge_en_o,
	output reg [PA_W-1:0] port_a_pull_enable_o,
	output reg [PB_W-1:0] port_b_pull_enable_o,
	// Timer controls
	output reg tof_irq_en_o,
	output reg rtif_irq_en_o,
	output reg [1:0] rt_rate_o,
	output reg tof_clr_o,
	output reg rtif_clr_o,
	// External interrupt controls
	output reg irq_en_o,
	output reg irq1_en_o,
	output reg irq_clr_o,
	output reg irq1_clr_o
);

	// Ports A and B share one synchroniser array
	// Total synchronised pin count
	localparam PIN_W = PA_W + PB_W;

	// Map: I/O window at the very bottom, RAM above it
	// User ROM, test ROM and vectors fill the top
	// Everything else is undecoded and inert
	// Only the first match counts, ranges never overlap
	// Region of an address
	function [2:0] mmd_region;
		input [AW-1:0] a;
		begin
			if (a <= `MMD_IO_HI) begin
				mmd_region = `MMD_RG_IO;
			end else if (a >= `MMD_RAM_LO && a <= `MMD_RAM_HI) begin
				mmd_region = `MMD_RG_RAM;
			end else if (a >= `MMD_UROM_LO && a <= `MMD_UROM_HI) begin
				mmd_region = `MMD_RG_UROM;
			end else if (a >= `MMD_TROM_LO && a <= `MMD_TROM_HI) begin
				mmd_region = `MMD_RG_TROM;
			end else if (a >= `MMD_VROM_LO) begin
				mmd_region = `MMD_RG_VROM;
			end else begin
				mmd_region = `MMD_RG_NONE;
			end
		end
	endfunction

	// Used by every write strobe and the read muxes
	// Region of the current access
	wire [2:0] region;
	assign region = mmd_region(addr_i);

	// Ports, timer and interrupt blocks share this strobe
	// Register write strobes, only inside the I/O window
	wire io_wr;
	assign io_wr = wr_i && (region == `MMD_RG_IO);

	// Stack pushes are ordinary RAM writes
	// RAM write, ROM and holes are never written
	wire ram_wr;
	assign ram_wr = wr_i && (region == `MMD_RG_RAM);

	// Pins change with no regard to our clock
	// First stage may go metastable; only stage two reads it
	// Stage three gives a second look before acceptance
	// Pin synchroniser chain
	reg [PIN_W-1:0] pin_s1_q;
	reg [PIN_W-1:0] pin_s2_q;
	reg [PIN_W-1:0] pin_s3_q;
	// Accepted pin levels
	reg [PIN_W-1:0] pin_q;
	// Raw pins joined
	wire [PIN_W-1:0] pin_raw;
	assign pin_raw = {pb_pin_i, pa_pin_i};

	// Three synchroniser flops and one accept flop per pin, accept once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_pin
			always @(posedge clk_i) begin
				if (reset_i) begin
					pin_s1_q[gi] <= 1'b0;
					pin_s2_q[gi] <= 1'b0;
					pin_s3_q[gi] <= 1'b0;
					pin_q[gi] <= 1'b0;
				end else begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
					pin_s3_q[gi] <= pin_s2_q[gi];
					// Take new level only when stable
					if (pin_s2_q[gi] == pin_s3_q[gi]) begin
						pin_q[gi] <= pin_s3_q[gi];
					end
				end
			end
		end
	endgenerate

	// Port A in the low bits, port B above it
	// Accepted levels per port
	wire [PA_W-1:0] pa_lvl;
	wire [PB_W-1:0] pb_lvl;
	assign pa_lvl = pin_q[PA_W-1:0];
	assign pb_lvl = pin_q[PIN_W-1:PA_W];

	// Latch keeps its value while the pin is an input
	// Port data registers
	always @(posedge clk_i) begin
		if (reset_i) begin
			port_a_output_latch_o <= `MMD_RST_BYTE;
			port_b_output_latch_o <= `MMD_RST_SIX;
		end else if (io_wr) begin
			// Bits 7 and 6 of port B are unimplemented
			if (addr_i == `MMD_PORT_A_OUTPUT_LATCH) begin
				port_a_output_latch_o <= wdata_i;
			end
			if (addr_i == `MMD_PORT_B_OUTPUT_LATCH) begin
				port_b_output_latch_o <= wdata_i[PB_W-1:0];
			end
		end
	end

	// A set bit lets the latch drive the pin
	// Direction registers, inputs after reset
	always @(posedge clk_i) begin
		if (reset_i) begin
			port_a_direction_o <= `MMD_RST_BYTE;
			port_b_direction_o <= `MMD_RST_SIX;
			slow_edge_en_o <= 1'b0;
		end else if (io_wr) begin
			if (addr_i == `MMD_PORT_A_DIRECTION) begin
				port_a_direction_o <= wdata_i;
			end
			if (addr_i == `MMD_PORT_B_DIRECTION) begin
				// Bit 6 is fixed at zero
				port_b_direction_o <= wdata_i[PB_W-1:0];
				slow_edge_en_o <= wdata_i[`MMD_DIRB_SLOW_BIT];
			end
		end
	end

	// No read back; software keeps its own copy
	// Pull device enables, write only
	always @(posedge clk_i) begin
		if (reset_i) begin
			port_a_pull_enable_o <= `MMD_RST_BYTE;
			port_b_pull_enable_o <= `MMD_RST_SIX;
		end else if (io_wr) begin
			if (addr_i == `MMD_PORT_A_PULL_ENABLE) begin
				port_a_pull_enable_o <= wdata_i;
			end
			if (addr_i == `MMD_PORT_B_PULL_ENABLE) begin
				port_b_pull_enable_o <= wdata_i[PB_W-1:0];
			end
		end
	end

	// Flags themselves live in the timer block
	// Writing one to a clear bit sends a pulse
	// Timer control bits and flag clear pulses
	always @(posedge clk_i) begin
		if (reset_i) begin
			tof_irq_en_o <= 1'b0;
			rtif_irq_en_o <= 1'b0;
			rt_rate_o <= `MMD_RST_TWO;
			tof_clr_o <= 1'b0;
			rtif_clr_o <= 1'b0;
		end else begin
			// Clear pulses last one cycle
			tof_clr_o <= 1'b0;
			rtif_clr_o <= 1'b0;
			if (io_wr && addr_i == `MMD_TIMER_CTRL_STATUS) begin
				tof_irq_en_o <= wdata_i[`MMD_TC_TOFE_BIT];
				rtif_irq_en_o <= wdata_i[`MMD_TC_RTIE_BIT];
				rt_rate_o <= wdata_i[1:0];
				tof_clr_o <= wdata_i[`MMD_TC_TOFR_BIT];
				rtif_clr_o <= wdata_i[`MMD_TC_RTIFR_BIT];
			end
		end
	end

	// Flags themselves live in the interrupt block
	// Interrupt enables and flag clear pulses
	always @(posedge clk_i) begin
		if (reset_i) begin
			irq_en_o <= 1'b0;
			irq1_en_o <= 1'b0;
			irq_clr_o <= 1'b0;
			irq1_clr_o <= 1'b0;
		end else begin
			// Clear pulses last one cycle
			irq_clr_o <= 1'b0;
			irq1_clr_o <= 1'b0;
			if (io_wr && addr_i == `MMD_EXT_IRQ_CTRL_STATUS) begin
				irq_en_o <= wdata_i[`MMD_IC_IRQE_BIT];
				irq1_en_o <= wdata_i[`MMD_IC_IRQE1_BIT];
				irq_clr_o <= wdata_i[`MMD_IC_IRQR_BIT];
				irq1_clr_o <= wdata_i[`MMD_IC_IRQR1_BIT];
			end
		end
	end

	// An input bit reads the synchronised pin level
	// Port read value: pin for inputs, latch for outputs
	wire [PA_W-1:0] pa_rd;
	wire [PB_W-1:0] pb_rd;
	assign pa_rd = (port_a_direction_o & port_a_output_latch_o) |
		(~port_a_direction_o & pa_lvl);
	assign pb_rd = (port_b_direction_o & port_b_output_latch_o) |
		(~port_b_direction_o & pb_lvl);

	// Fixed fill keeps reads repeatable
	// Register read mux; holes and test address read as fill
	reg [7:0] io_rd;
	always @* begin
		io_rd = `MMD_RD_FILL;
		case (addr_i)
			`MMD_PORT_A_OUTPUT_LATCH: begin
				io_rd = pa_rd;
			end
			`MMD_PORT_B_OUTPUT_LATCH: begin
				io_rd = {2'b00, pb_rd};
			end
			`MMD_PORT_A_DIRECTION: begin
				io_rd = port_a_direction_o;
			end
			`MMD_PORT_B_DIRECTION: begin
				io_rd = {slow_edge_en_o, 1'b0, port_b_direction_o};
			end
			`MMD_TIMER_CTRL_STATUS: begin
				io_rd = {tof_i, rtif_i, tof_irq_en_o, rtif_irq_en_o,
					2'b00, rt_rate_o};
			end
			`MMD_TIMER_COUNT_VALUE: begin
				io_rd = tmr_count_i;
			end
			`MMD_EXT_IRQ_CTRL_STATUS: begin
				io_rd = {irq_en_o, irq1_en_o, 2'b00,
					irqf_i, irqf1_i, 2'b00};
			end
			`MMD_FACTORY_TEST_REG: begin
				// Test register is invisible to the user
				io_rd = `MMD_RD_FILL;
			end
			default: begin
				// Write-only pull enables and holes
				io_rd = `MMD_RD_FILL;
			end
		endcase
	end

	// ROM bytes arrive combinationally for addr_i
	// Data for every region except RAM
	reg [7:0] alt_rd;
	always @* begin
		alt_rd = `MMD_RD_FILL;
		case (region)
			`MMD_RG_IO: begin
				alt_rd = io_rd;
			end
			`MMD_RG_UROM: begin
				alt_rd = urom_data_i;
			end
			`MMD_RG_VROM: begin
				alt_rd = urom_data_i;
			end
			`MMD_RG_TROM: begin
				alt_rd = trom_data_i;
			end
			default: begin
				// Undecoded space reads fill
				alt_rd = `MMD_RD_FILL;
			end
		endcase
	end

	// Upper address bits are already checked by region
	// Low six bits index RAM; stack pointer wraps within it
	wire [`MMD_RAM_AW-1:0] ram_idx;
	assign ram_idx = addr_i[`MMD_RAM_AW-1:0];

	// Non-RAM data pass through the same register
	// so every read answers exactly one cycle later
	// RAM whose read register is the bus read data
	mmd_ram #(
		.DEPTH(`MMD_RAM_DEPTH),
		.AW(`MMD_RAM_AW)
	) u_ram (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.wr_i(ram_wr),
		.waddr_i(ram_idx),
		.wdata_i(wdata_i),
		.rd_i(rd_i),
		.raddr_i(ram_idx),
		.alt_sel_i(region != `MMD_RG_RAM),
		.alt_data_i(alt_rd),
		.rdata_o(rdata_o)
	);

endmodule
`default_nettype wire

// ### mmd_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the ROM arrays behind the decoder
module mmd_rom_model (
	// Address from the bus
	input wire logic [10:0] addr_i,
	// Byte patterns, distinct per array
	output logic [7:0] urom_data_o,
	output logic [7:0] trom_data_o
);
	// Address-keyed contents so a wrong mux shows
	assign urom_data_o = addr_i[7:0] ^ 8'h5a;
	assign trom_data_o = ~addr_i[7:0];
endmodule
`default_nettype wire

// ### mmd_map_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Protocol and map checks at the decoder ports
module mmd_map_checker #(
	parameter AW = 11,
	parameter PA_W = 8
) (
	// Clock and bus
	input wire clk_i,
	input wire reset_i,
	input wire [AW-1:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	// Status sources
	input wire [7:0] tmr_count_i,
	input wire irqf_i,
	input wire irqf1_i,
	// Watched outputs
	input wire [PA_W-1:0] port_a_output_latch_o,
	input wire [PA_W-1:0] port_a_direction_o,
	input wire tof_clr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Holes, pull enables and test slot read as zero
	wire hole = addr_i inside {11'h002, 11'h003, 11'h006, 11'h007, [11'h00b:11'h00f], [11'h010:11'h01f]};
	chk_dir_write: assert property (wr_i && addr_i == 11'h004 |=> port_a_direction_o == $past(wdata_i))
		else $error("direction write not taken");
	chk_latch_write: assert property (wr_i && addr_i == 11'h000 |=> port_a_output_latch_o == $past(wdata_i))
		else $error("latch write not taken");
	chk_port_readback: assert property (rd_i && addr_i == 11'h000 && (&port_a_direction_o)
		|=> rdata_o == $past(port_a_output_latch_o))
		else $error("output port read wrong");
	chk_tof_clr_pulse: assert property (wr_i && addr_i == 11'h008 && wdata_i[3] |=> tof_clr_o ##1
		(!tof_clr_o || $past(wr_i && addr_i == 11'h008 && wdata_i[3])))
		else $error("clear pulse wrong");
	chk_count_read: assert property (rd_i && addr_i == 11'h009 |=> rdata_o == $past(tmr_count_i))
		else $error("count read wrong");
	chk_irq_read: assert property (rd_i && addr_i == 11'h00a
		|=> rdata_o[5:0] == {2'b00, $past(irqf_i), $past(irqf1_i), 2'b00})
		else $error("irq status read wrong");
	chk_hole_read_zero: assert property (rd_i && hole |=> rdata_o == 8'h00)
		else $error("hole read not zero");
	chk_rom_write_inert: assert property (wr_i && (addr_i >= 11'h300 || addr_i == 11'h01f)
		|=> $stable(port_a_direction_o) && $stable(port_a_output_latch_o))
		else $error("ignored write changed state");
endmodule
bind mmd_memory_map_decode mmd_map_checker #(.AW(AW), .PA_W(PA_W)) u_chk (.clk_i(clk_i), .reset_i(reset_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tmr_count_i(tmr_count_i),
	.irqf_i(irqf_i), .irqf1_i(irqf1_i), .port_a_output_latch_o(port_a_output_latch_o),
	.port_a_direction_o(port_a_direction_o), .tof_clr_o(tof_clr_o));
`default_nettype wire

// ### mcu_memory_map_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_memory_map_decode_bench;
	// Driven inputs
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [10:0] addr_i = 11'h000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] pa_pin_i = 8'h3c;
	logic [5:0] pb_pin_i = 6'h15;
	logic tof_i = 1'b1;
	logic rtif_i = 1'b0;
	logic [7:0] tmr_count_i = 8'h5e;
	logic irqf_i = 1'b1;
	logic irqf1_i = 1'b0;
	// Observed outputs
	wire [7:0] rdata_o, urom, trom, pa_q, pa_dir, pa_pull;
	wire [5:0] pb_q, pb_dir, pb_pull;
	wire [1:0] rt_rate;
	wire slow_en, tof_en, rtif_en, tof_clr, rtif_clr, irq_en, irq1_en, irq_clr, irq1_clr;
	integer fails = 0, num_checks = 0, cycles = 0, i;
	reg [10:0] a;
	// Probe addresses around every region edge
	localparam [109:0] PROBES = {11'h2ff, 11'h300, 11'h7cf, 11'h7d0, 11'h7f7,
		11'h7f8, 11'h7ff, 11'h100, 11'h020, 11'h0bf};
	mmd_memory_map_decode i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .urom_data_i(urom), .trom_data_i(trom),
		.pa_pin_i(pa_pin_i), .pb_pin_i(pb_pin_i), .tof_i(tof_i), .rtif_i(rtif_i), .tmr_count_i(tmr_count_i),
		.irqf_i(irqf_i), .irqf1_i(irqf1_i), .port_a_output_latch_o(pa_q), .port_b_output_latch_o(pb_q),
		.port_a_direction_o(pa_dir), .port_b_direction_o(pb_dir), .slow_edge_en_o(slow_en),
		.port_a_pull_enable_o(pa_pull), .port_b_pull_enable_o(pb_pull), .tof_irq_en_o(tof_en),
		.rtif_irq_en_o(rtif_en), .rt_rate_o(rt_rate), .tof_clr_o(tof_clr), .rtif_clr_o(rtif_clr),
		.irq_en_o(irq_en), .irq1_en_o(irq1_en), .irq_clr_o(irq_clr), .irq1_clr_o(irq1_clr));
	mmd_rom_model i_rom (.addr_i(addr_i), .urom_data_o(urom), .trom_data_o(trom));
	// 200 MHz clock
	always #2.5 clk_i = ~clk_i;
	// Hang guard
	always @(posedge clk_i) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			tally_and_finish;
		end
	end
	// Compare and count
	task check(input [7:0] seen, input [7:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One-cycle write strobe
	task wr(input [10:0] ad, input [7:0] dt);
		@(posedge clk_i);
		addr_i <= ad;
		wdata_i <= dt;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// One-cycle read, data taken the cycle after
	task rdc(input [10:0] ad, input [7:0] exp);
		@(posedge clk_i);
		addr_i <= ad;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		check(rdata_o, exp);
	endtask
	// Expected byte per region
	function [7:0] rom_exp(input [10:0] ad);
		if ((ad >= 11'h300 && ad <= 11'h7cf) || ad >= 11'h7f8)
			rom_exp = ad[7:0] ^ 8'h5a;
		else if (ad >= 11'h7d0)
			rom_exp = ~ad[7:0];
		else
			rom_exp = 8'h00;
	endfunction
	task tally_and_finish;
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rdc(11'h004, 8'h00);
		rdc(11'h001, 8'h15);
		$display("test reset done");
		wr(11'h004, 8'hff);
		wr(11'h000, 8'ha5);
		rdc(11'h000, 8'ha5);
		rdc(11'h004, 8'hff);
		check(pa_q, 8'ha5);
		wr(11'h004, 8'h0f);
		rdc(11'h000, 8'h35);
		wr(11'h005, 8'hff);
		wr(11'h001, 8'hff);
		rdc(11'h005, 8'hbf);
		rdc(11'h001, 8'h3f);
		check({7'h00, slow_en}, 8'h01);
		check({2'b00, pb_dir}, 8'h3f);
		check({2'b00, pb_q}, 8'h3f);
		wr(11'h002, 8'h00);
		wr(11'h006, 8'h00);
		wr(11'h01f, 8'h00);
		rdc(11'h004, 8'h0f);
		rdc(11'h01f, 8'h00);
		rdc(11'h003, 8'h00);
		$display("test ports done");
		wr(11'h008, 8'hff);
		#1;
		check({tof_clr, rtif_clr, tof_en, rtif_en, rt_rate}, 8'h3f);
		rdc(11'h008, 8'hb3);
		check({tof_clr, rtif_clr}, 8'h00);
		wr(11'h009, 8'h00);
		rdc(11'h009, 8'h5e);
		wr(11'h00a, 8'hff);
		#1;
		check({irq_en, irq1_en, irq_clr, irq1_clr}, 8'h0f);
		rdc(11'h00a, 8'hc8);
		wr(11'h00b, 8'hff);
		rdc(11'h00b, 8'h00);
		wr(11'h010, 8'h81);
		wr(11'h011, 8'hff);
		#1;
		check(pa_pull, 8'h81);
		check({2'b00, pb_pull}, 8'h3f);
		rdc(11'h010, 8'h00);
		$display("test control done");
		for (i = 0; i < 64; i = i + 1)
			wr(11'h0c0 + i[10:0], i[7:0] ^ 8'hc3);
		wr(11'h300, 8'h00);
		wr(11'h100, 8'h00);
		for (i = 0; i < 64; i = i + 1)
			rdc(11'h0c0 + i[10:0], i[7:0] ^ 8'hc3);
		// Working byte at the top, low end left for deep stacking
		wr(11'h0ff, 8'h77);
		rdc(11'h0ff, 8'h77);
		$display("test ram done");
		for (i = 0; i < 10; i = i + 1) begin
			a = PROBES[i*11 +: 11];
			rdc(a, rom_exp(a));
		end
		$display("test rom done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
